/* File: rtl/deframer_cfg_pkg.sv */
// Constants for the lane deframer configuration and check logic
package deframer_cfg_pkg;

    // ****
    // Register offsets
    // ****
    localparam logic [14:0] ADDR_CHECK_FLAGS   = 15'h0030;
    localparam logic [14:0] ADDR_MF_DELAY      = 15'h0304;
    localparam logic [14:0] ADDR_LANE_CTRL     = 15'h0453;
    localparam logic [14:0] ADDR_OPF_M1        = 15'h0454;
    localparam logic [14:0] ADDR_MF_LEN        = 15'h0455;
    localparam logic [14:0] ADDR_CONV_CNT      = 15'h0456;
    localparam logic [14:0] ADDR_RESOLUTION    = 15'h0457;
    localparam logic [14:0] ADDR_PACKING       = 15'h0458;
    localparam logic [14:0] ADDR_VERSION       = 15'h0459;
    localparam logic [14:0] ADDR_DENSITY       = 15'h045a;
    localparam logic [14:0] ADDR_DESKEW_MASK   = 15'h046c;
    localparam logic [14:0] ADDR_OPF           = 15'h0476;
    localparam logic [14:0] ADDR_LANE_EN       = 15'h047d;

    // ****
    // Values after reset (mode 4, lanes off)
    // ****
    localparam logic [7:0] RST_MF_DELAY    = 8'h00;
    localparam logic [7:0] RST_LANE_CTRL   = 8'h03;
    localparam logic [7:0] RST_OPF_M1      = 8'h00;
    localparam logic [7:0] RST_MF_LEN      = 8'h1f;
    localparam logic [7:0] RST_CONV_CNT    = 8'h01;
    localparam logic [7:0] RST_RESOLUTION  = 8'h0f;
    localparam logic [7:0] RST_PACKING     = 8'h0f;
    localparam logic [7:0] RST_VERSION     = 8'h20;
    localparam logic [7:0] RST_DENSITY     = 8'h80;
    localparam logic [7:0] RST_DESKEW_MASK = 8'h00;
    localparam logic [7:0] RST_OPF         = 8'h01;
    localparam logic [7:0] RST_LANE_EN     = 8'h00;

    // ****
    // Field positions and values
    // ****
    localparam int          BIT_SCRAMBLE     = 7;
    localparam int          BIT_HD           = 7;
    localparam int          FLAG_DELAY       = 5;
    localparam int          FLAG_PARAM       = 4;
    localparam int          FLAG_COMBO       = 3;
    localparam int          FLAG_K           = 2;
    localparam int          FLAG_SUBCLASS    = 1;
    localparam logic [4:0]  K_M1_16          = 5'h0f;
    localparam logic [4:0]  K_M1_32          = 5'h1f;
    localparam logic [4:0]  RES_M1_16        = 5'h0f;
    localparam logic [2:0]  SUBCLASS_MAX     = 3'h1;
    localparam logic [2:0]  VERSION_B        = 3'h1;

    // ****
    // Serial port framing
    // ****
    localparam logic [4:0]  SPI_INSTR_BITS   = 5'h10;
    localparam logic [4:0]  SPI_FRAME_BITS   = 5'h18;

    typedef enum logic [3:0] {
        MODE_NONE = 4'b0000,
        MODE_4    = 4'b0100,
        MODE_5    = 4'b0101,
        MODE_6    = 4'b0110,
        MODE_7    = 4'b0111,
        MODE_9    = 4'b1001,
        MODE_10   = 4'b1010
    } link_mode_t;

endpackage

/* File: rtl/lane_deframer_config.sv */
// Deframer configuration, checks and sample regrouping
// Overview of operation
// RULE1 - Link parameters steer octet regrouping into samples.
// RULE2 - Single link accepts modes 4 to 10 except 8.
// RULE3 - Flag bit 5: illegal multiframe clock delay.
// RULE4 - Flag bit 3: unsupported L, M, F, S combination.
// RULE5 - Flag bit 2: illegal frames per multiframe.
// RULE6 - Flag bit 1: illegal subclass version field.
// RULE7 - Capture only when configured, deskewed, then enabled.
// RULE8 - Deskew mask bit x deskews lane x; zero is unused.
// RULE9 - Enable bit x enables lane x, after the deskew mask.
// RULE10 - Lane control: bit 7 descrambles, bits 4:0 lanes less one.
// RULE11 - F less one and F registers must agree.
// RULE12 - Multiframe length holds K less one: 0x0F or 0x1F.
// RULE13 - Converter count holds M less one.
// RULE14 - Resolution: bits 7:6 zero, bits 4:0 0x0F.
// RULE15 - Packing: bits 7:5 subclass 0 or 1, bits 4:0 0xF.
// RULE16 - Version bits 7:5 one; bits 4:0 S less one.
// RULE17 - Density bit 7 is HD; bits 4:0 zero.
// RULE18 - Mode 4: L4, M2, S1, F1, K32, HD.
// RULE19 - Mode 5: L4, M2, S2, F2, no HD.
// RULE20 - Mode 6: L2, M2, S1, F2, mask 0x03.
// RULE21 - Four lanes need both masks 0x0F.
// RULE22 - K is 32 in modes 4 and 9.
// RULE23 - HD set exactly when F is one.
// RULE24 - Flags follow register contents, clearing once corrected.
`timescale 1ns/10ps
`default_nettype none
module lane_deframer_config
    import deframer_cfg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        spi_csb_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    output logic             spi_sdo_oe,
    input  wire logic [31:0] lane_octets,
    input  wire logic        lane_valid,
    output logic             lane_ready,
    output logic             sample_valid,
    input  wire logic        sample_ready,
    output logic [31:0]      sample_data,
    output logic             sample_two,
    output logic [1:0]       sample_conv,
    output logic             descramble_en,
    output logic             capture_en,
    output logic [3:0]       link_mode,
    output logic [7:0]       lanes_active
);

    // ****
    // Functions
    // ****
    function automatic link_mode_t mode_of(input logic [4:0] l_m1, input logic [7:0] m_m1,
                                           input logic [7:0] f_m1, input logic [4:0] s_m1);
        link_mode_t m;
        m = MODE_NONE;
        if      (l_m1 == 5'h03 && m_m1 == 8'h01 && f_m1 == 8'h00 && s_m1 == 5'h00) m = MODE_4;
        else if (l_m1 == 5'h03 && m_m1 == 8'h01 && f_m1 == 8'h01 && s_m1 == 5'h01) m = MODE_5;
        else if (l_m1 == 5'h01 && m_m1 == 8'h01 && f_m1 == 8'h01 && s_m1 == 5'h00) m = MODE_6;
        else if (l_m1 == 5'h00 && m_m1 == 8'h01 && f_m1 == 8'h03 && s_m1 == 5'h00) m = MODE_7;
        else if (l_m1 == 5'h01 && m_m1 == 8'h00 && f_m1 == 8'h00 && s_m1 == 5'h00) m = MODE_9;
        else if (l_m1 == 5'h00 && m_m1 == 8'h00 && f_m1 == 8'h01 && s_m1 == 5'h00) m = MODE_10;
        return m;
    endfunction

    function automatic logic [7:0] lane_mask(input logic [4:0] l_m1);
        logic [7:0] r;
        r = 8'h00;
        if      (l_m1 == 5'h00) r = 8'h01;
        else if (l_m1 == 5'h01) r = 8'h03;
        else if (l_m1 == 5'h03) r = 8'h0f;
        return r;
    endfunction

    function automatic logic conv_of(input logic [1:0] idx, input logic two_per);
        return two_per ? idx[1] : idx[0];
    endfunction

    // ****
    // Pin synchronisers
    // ****
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s3_r;
    logic [2:0] pin_r;
    wire  [2:0] pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_s1_r <= 3'h1;
            pin_s2_r <= 3'h1;
            pin_s3_r <= 3'h1;
            pin_r    <= 3'h1;
        end else begin
            pin_s1_r <= {spi_sdi, spi_sclk, spi_csb_n};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_r    <= pin_nxt;
        end
    end

    wire sel      = ~pin_r[0];
    wire sclk_up  = sel && pin_nxt[1] && !pin_r[1];
    wire sclk_dn  = sel && !pin_nxt[1] && pin_r[1];

    // ****
    // Serial register port
    // ****
    logic [4:0]  bit_cnt_r;
    logic [15:0] instr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rshift_r;
    logic        sdo_oe_r;
    logic [7:0]  rd_val;

    wire  [15:0] instr_nxt = {instr_r[14:0], pin_nxt[2]};
    wire  [7:0]  wdata_nxt = {wdata_r[6:0], pin_nxt[2]};
    wire         is_read   = instr_r[15];
    wire  [14:0] addr      = instr_r[14:0];
    wire         wr_stb    = sclk_up && !is_read && bit_cnt_r == SPI_FRAME_BITS - 5'h01;
    wire         rd_load   = sclk_up && bit_cnt_r == SPI_INSTR_BITS - 5'h01 && instr_nxt[15];

    always_ff @(posedge sys_clk) begin
        if (reset || !sel) begin
            bit_cnt_r <= 5'h00;
            instr_r   <= 16'h0000;
            wdata_r   <= 8'h00;
            rshift_r  <= 8'h00;
            sdo_oe_r  <= 1'b0;
        end else begin
            if (sclk_up && bit_cnt_r < SPI_FRAME_BITS) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r < SPI_INSTR_BITS) begin
                    instr_r <= instr_nxt;
                end else begin
                    wdata_r <= wdata_nxt;
                end
            end
            if (rd_load) begin
                sdo_oe_r <= 1'b1;
            end else if (sclk_dn && sdo_oe_r && bit_cnt_r == SPI_INSTR_BITS) begin
                rshift_r <= rd_val;
            end else if (sclk_dn && sdo_oe_r) begin
                rshift_r <= {rshift_r[6:0], 1'b0};
            end
            if (bit_cnt_r == SPI_FRAME_BITS && sclk_dn) begin
                sdo_oe_r <= 1'b0;
            end
        end
    end

    assign spi_sdo    = rshift_r[7];
    assign spi_sdo_oe = sdo_oe_r;

    // ****
    // Configuration registers
    // ****
    logic [7:0] mf_delay_r;
    logic [7:0] lane_ctrl_r;
    logic [7:0] opf_m1_r;
    logic [7:0] mf_len_r;
    logic [7:0] conv_cnt_r;
    logic [7:0] resolution_r;
    logic [7:0] packing_r;
    logic [7:0] version_r;
    logic [7:0] density_r;
    logic [7:0] deskew_mask_r;
    logic [7:0] opf_r;
    logic [7:0] lane_en_r;
    logic       en_after_deskew_r;
    wire  [7:0] wd = wdata_nxt;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mf_delay_r        <= RST_MF_DELAY;
            lane_ctrl_r       <= RST_LANE_CTRL;
            opf_m1_r          <= RST_OPF_M1;
            mf_len_r          <= RST_MF_LEN;
            conv_cnt_r        <= RST_CONV_CNT;
            resolution_r      <= RST_RESOLUTION;
            packing_r         <= RST_PACKING;
            version_r         <= RST_VERSION;
            density_r         <= RST_DENSITY;
            deskew_mask_r     <= RST_DESKEW_MASK;
            opf_r             <= RST_OPF;
            lane_en_r         <= RST_LANE_EN;
            en_after_deskew_r <= 1'b0;
        end else if (wr_stb) begin
            if (addr == ADDR_MF_DELAY)    mf_delay_r   <= wd;
            if (addr == ADDR_LANE_CTRL)   lane_ctrl_r  <= wd; // see RULE10
            if (addr == ADDR_OPF_M1)      opf_m1_r     <= wd;
            if (addr == ADDR_MF_LEN)      mf_len_r     <= wd; // see RULE12
            if (addr == ADDR_CONV_CNT)    conv_cnt_r   <= wd; // see RULE13
            if (addr == ADDR_RESOLUTION)  resolution_r <= wd;
            if (addr == ADDR_PACKING)     packing_r    <= wd; // see RULE15
            if (addr == ADDR_VERSION)     version_r    <= wd; // see RULE16
            if (addr == ADDR_DENSITY)     density_r    <= wd; // see RULE17
            if (addr == ADDR_OPF)         opf_r        <= wd; // see RULE11
            if (addr == ADDR_DESKEW_MASK) begin
                deskew_mask_r     <= wd; // see RULE8
                en_after_deskew_r <= 1'b0;
            end
            if (addr == ADDR_LANE_EN) begin
                lane_en_r         <= wd; // see RULE9
                en_after_deskew_r <= 1'b1;
            end
        end
    end

    // ****
    // Configuration checks
    // ****
    wire [4:0] l_m1     = lane_ctrl_r[4:0];
    wire [4:0] k_m1     = mf_len_r[4:0];
    wire [4:0] s_m1     = version_r[4:0];
    wire       f_is_one = (opf_m1_r == 8'h00);
    link_mode_t mode;
    assign mode = mode_of(l_m1, conv_cnt_r, opf_m1_r, s_m1); // see RULE2, RULE18, RULE19, RULE20

    wire flag_combo    = (mode == MODE_NONE); // see RULE4
    wire flag_k        = !(k_m1 == K_M1_16 || k_m1 == K_M1_32)
                         || (f_is_one && k_m1 != K_M1_32); // see RULE5, RULE22
    wire flag_subclass = packing_r[7:5] > SUBCLASS_MAX; // see RULE6
    wire flag_delay    = mf_delay_r > {3'h0, k_m1}; // see RULE3
    wire flag_param    = (opf_r != opf_m1_r + 8'h01) // see RULE11
                         || resolution_r[4:0] != RES_M1_16 || resolution_r[7:6] != 2'h0 // see RULE14
                         || packing_r[4:0] != RES_M1_16
                         || version_r[7:5] != VERSION_B
                         || density_r[4:0] != 5'h00 // see RULE17
                         || density_r[BIT_HD] != f_is_one; // see RULE23

    // Pure decode of registers
    wire [7:0] check_flags = 8'h00 // see RULE24
                             | (8'(flag_delay)    << FLAG_DELAY)
                             | (8'(flag_param)    << FLAG_PARAM)
                             | (8'(flag_combo)    << FLAG_COMBO)
                             | (8'(flag_k)        << FLAG_K)
                             | (8'(flag_subclass) << FLAG_SUBCLASS);

    wire [7:0] need_mask = lane_mask(l_m1);
    wire       lanes_ok  = (deskew_mask_r == need_mask) && (lane_en_r == deskew_mask_r); // see RULE21
    assign capture_en    = (check_flags == 8'h00) && lanes_ok && en_after_deskew_r; // see RULE7
    assign descramble_en = lane_ctrl_r[BIT_SCRAMBLE]; // see RULE10
    assign link_mode     = mode;
    assign lanes_active  = capture_en ? lane_en_r : 8'h00; // see RULE9

    // ****
    // Register readback
    // ****
    always_comb begin
        unique case (addr)
            ADDR_CHECK_FLAGS:  rd_val = check_flags;
            ADDR_MF_DELAY:     rd_val = mf_delay_r;
            ADDR_LANE_CTRL:    rd_val = lane_ctrl_r;
            ADDR_OPF_M1:       rd_val = opf_m1_r;
            ADDR_MF_LEN:       rd_val = mf_len_r;
            ADDR_CONV_CNT:     rd_val = conv_cnt_r;
            ADDR_RESOLUTION:   rd_val = resolution_r;
            ADDR_PACKING:      rd_val = packing_r;
            ADDR_VERSION:      rd_val = version_r;
            ADDR_DENSITY:      rd_val = density_r;
            ADDR_DESKEW_MASK:  rd_val = deskew_mask_r;
            ADDR_OPF:          rd_val = opf_r;
            ADDR_LANE_EN:      rd_val = lane_en_r;
            default:           rd_val = 8'h00;
        endcase
    end

    // ****
    // Sample regrouping
    // ****
    sample_stream_if stream ();

    logic       half_r;
    logic [7:0] hold_r;
    logic [1:0] idx_r;

    wire       four_lane = (l_m1 == 5'h03);
    wire       one_lane  = (l_m1 == 5'h00);
    wire       two_per   = (s_m1 == 5'h01);
    wire [1:0] ms_m1     = {conv_cnt_r[0], s_m1[0]} == 2'b11 ? 2'h3 :
                           (conv_cnt_r[0] | s_m1[0]) ? 2'h1 : 2'h0;
    wire       beat      = lane_valid && lane_ready;
    wire [1:0] idx_b     = (idx_r == ms_m1) ? 2'h0 : idx_r + 2'h1;
    wire [1:0] step      = four_lane ? 2'h2 : 2'h1;
    wire [1:0] idx_sum   = idx_r + step;
    wire [1:0] idx_nxt   = (ms_m1 == 2'h0) ? 2'h0 : (idx_sum & ms_m1);

    assign lane_ready   = capture_en && stream.ready; // see RULE7
    assign stream.valid = capture_en && lane_valid && (!one_lane || half_r);
    assign stream.two   = four_lane;
    assign stream.conv  = {conv_of(idx_b, two_per), conv_of(idx_r, two_per)}; // see RULE1
    assign stream.data  = one_lane  ? {16'h0000, hold_r, lane_octets[7:0]} :
                          four_lane ? {lane_octets[23:16], lane_octets[31:24],
                                       lane_octets[7:0], lane_octets[15:8]} :
                                      {16'h0000, lane_octets[7:0], lane_octets[15:8]}; // see RULE1

    always_ff @(posedge sys_clk) begin
        if (reset || !capture_en) begin
            half_r <= 1'b0;
            hold_r <= 8'h00;
            idx_r  <= 2'h0;
        end else if (beat) begin
            if (one_lane && !half_r) begin
                half_r <= 1'b1;
                hold_r <= lane_octets[7:0];
            end else begin
                half_r <= 1'b0;
                idx_r  <= idx_nxt;
            end
        end
    end

    sample_skid_buffer u_buf (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_s      (stream.snk),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (sample_data),
        .out_two   (sample_two),
        .out_conv  (sample_conv)
    );

endmodule
`default_nettype wire

/* File: rtl/sample_skid_buffer.sv */
// Two-entry sample buffer toward the converters
`timescale 1ns/10ps
`default_nettype none
module sample_skid_buffer
    import deframer_cfg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    sample_stream_if.snk     in_s,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [31:0]      out_data,
    output logic             out_two,
    output logic [1:0]       out_conv
);
    logic [34:0] mem_r [2];
    logic        wr_ptr_r;
    logic        rd_ptr_r;
    logic [1:0]  count_r;
    wire         push = in_s.valid && in_s.ready;
    wire         pop  = out_valid && out_ready;

    assign in_s.ready = (count_r != 2'h2);
    assign out_valid  = (count_r != 2'h0);
    assign out_data   = mem_r[rd_ptr_r][31:0];
    assign out_two    = mem_r[rd_ptr_r][32];
    assign out_conv   = mem_r[rd_ptr_r][34:33];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= {in_s.conv, in_s.two, in_s.data};
                wr_ptr_r        <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

/* File: rtl/sample_stream_if.sv */
// Sample stream carrier between the deframer and its output buffer
`timescale 1ns/10ps
`default_nettype none
interface sample_stream_if;
    logic        valid;
    logic        ready;
    logic [31:0] data;
    logic        two;
    logic [1:0]  conv;

    modport src (output valid, output data, output two, output conv, input ready);
    modport snk (input valid, input data, input two, input conv, output ready);
endinterface
`default_nettype wire

/* File: tb/lane_deframer_config_chk.sv */
// Assertions on the deframer configuration block ports
`timescale 1ns/10ps
`default_nettype none
module lane_deframer_config_chk (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        lane_valid,
    input wire logic        lane_ready,
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic [31:0] sample_data,
    input wire logic [1:0]  sample_conv,
    input wire logic        capture_en,
    input wire logic [3:0]  link_mode,
    input wire logic [7:0]  lanes_active
);
    // ********
    // Port relations
    // ********
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_ready_needs_cap: assert property (lane_ready |-> capture_en)
        else $error("lane ready while capture off");
    a_cap_needs_mode: assert property (capture_en |-> link_mode != 4'h0)
        else $error("capture on in unsupported mode");
    a_mode_legal: assert property (link_mode inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha})
        else $error("mode number not allowed");
    a_lanes_gated: assert property (!capture_en |-> lanes_active == 8'h00)
        else $error("lanes active while capture off");
    a_four_lane_mask: assert property (capture_en && link_mode inside {4'h4, 4'h5} |-> lanes_active == 8'h0f)
        else $error("four lane mode mask wrong");
    a_two_lane_mask: assert property (capture_en && link_mode == 4'h6 |-> lanes_active == 8'h03)
        else $error("mode 6 mask wrong");
    a_head_holds: assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
        else $error("head sample changed while stalled");
    a_beat_gives_sample: assert property (capture_en && link_mode == 4'h6 && lane_valid && lane_ready |=> sample_valid)
        else $error("beat gave no sample");
    c_capture: cover property (capture_en && lane_valid && lane_ready);
    c_stall: cover property (sample_valid && !sample_ready ##1 !lane_ready);
    c_conv_b: cover property (sample_valid && sample_conv[0]);
endmodule
bind lane_deframer_config lane_deframer_config_chk lane_deframer_config_chk_inst (.sys_clk(sys_clk), .reset(reset),
    .lane_valid(lane_valid), .lane_ready(lane_ready), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .sample_conv(sample_conv), .capture_en(capture_en), .link_mode(link_mode),
    .lanes_active(lanes_active));
`default_nettype wire

/* File: tb/lane_tx_model.sv */
// Lane transmitter model sending numbered octet beats
`timescale 1ns/10ps
`default_nettype none
module lane_tx_model (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  load,
    input  wire logic        lane_ready,
    output logic [31:0]      lane_octets,
    output logic             lane_valid,
    output logic [3:0]       left
);
    // ********
    // Beat source
    // ********
    logic [3:0]  idx_r;
    logic [31:0] cur_w;
    assign cur_w       = 32'h4433_2211 + {4{4'h0, idx_r}};
    assign lane_valid  = left != 4'h0;
    // Beat held until taken; idle lanes show the inverse of the last beat
    assign lane_octets = lane_valid ? cur_w : ~(cur_w - 32'h0101_0101);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            left  <= 4'h0;
            idx_r <= 4'h0;
        end else if (load != 4'h0 && left == 4'h0) begin
            left <= load;
        end else if (lane_valid && lane_ready) begin
            left  <= left - 4'h1;
            idx_r <= idx_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/serial_link_deframer_config_test.sv */
// Self-checking bench for the deframer configuration block
`timescale 1ns/10ps
`default_nettype none
module serial_link_deframer_config_test import deframer_cfg_pkg::*;;
    logic        sys_clk, reset, spi_csb_n, spi_sclk, spi_sdi, sample_ready, spi_sdo, spi_sdo_oe;
    logic        lane_valid, lane_ready, sample_valid, sample_two, descramble_en, capture_en;
    logic [31:0] lane_octets, sample_data;
    logic [1:0]  sample_conv;
    logic [3:0]  link_mode, load, left;
    logic [7:0]  lanes_active, rd;
    int          err_count, n_compared, cycles;
    // Rows: mode, lane ctrl, F-1, K-1, M-1, S-1, density, lane mask
    localparam logic [59:0] MODES [6] = '{60'h403_001f_0100_800f, 60'h583_010f_0101_000f, 60'h601_011f_0100_0003,
        60'h780_030f_0100_0001, 60'h901_001f_0000_8003, 60'ha80_010f_0000_0001};
    localparam logic [22:0] RTAB [12] = '{{ADDR_MF_DELAY, RST_MF_DELAY}, {ADDR_LANE_CTRL, RST_LANE_CTRL},
        {ADDR_OPF_M1, RST_OPF_M1}, {ADDR_MF_LEN, RST_MF_LEN}, {ADDR_CONV_CNT, RST_CONV_CNT},
        {ADDR_RESOLUTION, RST_RESOLUTION}, {ADDR_PACKING, RST_PACKING}, {ADDR_VERSION, RST_VERSION},
        {ADDR_DENSITY, RST_DENSITY}, {ADDR_DESKEW_MASK, RST_DESKEW_MASK}, {ADDR_OPF, RST_OPF}, {ADDR_LANE_EN, RST_LANE_EN}};
    lane_deframer_config lane_deframer_config_inst (.sys_clk(sys_clk), .reset(reset), .spi_csb_n(spi_csb_n),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .lane_octets(lane_octets),
        .lane_valid(lane_valid), .lane_ready(lane_ready), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .sample_two(sample_two), .sample_conv(sample_conv), .descramble_en(descramble_en),
        .capture_en(capture_en), .link_mode(link_mode), .lanes_active(lanes_active));
    lane_tx_model lane_tx_model_inst (.sys_clk(sys_clk), .reset(reset), .load(load), .lane_ready(lane_ready),
        .lane_octets(lane_octets), .lane_valid(lane_valid), .left(left));
    // ********
    // Clock, shared tasks and scenarios
    // ********
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] fr;
        fr = {rw, a, d};
        spi_csb_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi = fr[i];
            tick(8);
            if (i < 8) rd[i] = spi_sdo;
            if (i == 0) chk("sdo_oe", 32'(spi_sdo_oe), 32'(rw));
            spi_sclk = 1'b1;
            tick(8);
            spi_sclk = 1'b0;
        end
        tick(8);
        spi_csb_n = 1'b1;
        tick(8);
    endtask
    task rchk(input logic [14:0] a, input logic [7:0] e);
        spi(1'b1, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, rd}, {24'h0, e});
    endtask
    task cfg(input logic [59:0] r);
        spi(1'b0, ADDR_LANE_CTRL, r[55:48]);
        spi(1'b0, ADDR_OPF_M1, r[47:40]);
        spi(1'b0, ADDR_OPF, r[47:40] + 8'h01);
        spi(1'b0, ADDR_MF_LEN, r[39:32]);
        spi(1'b0, ADDR_CONV_CNT, r[31:24]);
        spi(1'b0, ADDR_VERSION, r[23:16] | 8'h20);
        spi(1'b0, ADDR_DENSITY, r[15:8]);
        spi(1'b0, ADDR_DESKEW_MASK, r[7:0]);
        spi(1'b0, ADDR_LANE_EN, r[7:0]);
        tick(8);
    endtask
    task t_reset;
        for (int i = 0; i < 12; i++) rchk(RTAB[i][22:8], RTAB[i][7:0]);
        spi(1'b0, ADDR_CHECK_FLAGS, 8'hff);
        rchk(ADDR_CHECK_FLAGS, 8'h00);
        rchk(15'h0123, 8'h00);
        chk("link_mode", 32'(link_mode), 32'h4);
        chk("capture_en", 32'(capture_en), 32'h0);
        $display("t_reset done");
    endtask
    task t_flags;
        spi(1'b0, ADDR_MF_LEN, 8'h0f);
        rchk(ADDR_CHECK_FLAGS, 8'h04);
        spi(1'b0, ADDR_MF_LEN, 8'h1f);
        spi(1'b0, ADDR_PACKING, 8'h4f);
        rchk(ADDR_CHECK_FLAGS, 8'h02);
        spi(1'b0, ADDR_PACKING, 8'h2f);
        spi(1'b0, ADDR_MF_DELAY, 8'h20);
        rchk(ADDR_CHECK_FLAGS, 8'h20);
        spi(1'b0, ADDR_MF_DELAY, 8'h1f);
        spi(1'b0, ADDR_DENSITY, 8'h00);
        rchk(ADDR_CHECK_FLAGS, 8'h10);
        spi(1'b0, ADDR_DENSITY, 8'h80);
        spi(1'b0, ADDR_LANE_CTRL, 8'h02);
        chk("link_mode", 32'(link_mode), 32'h0);
        rchk(ADDR_CHECK_FLAGS, 8'h08);
        spi(1'b0, ADDR_LANE_CTRL, 8'h03);
        rchk(ADDR_CHECK_FLAGS, 8'h00);
        spi(1'b0, ADDR_MF_DELAY, 8'h00);
        $display("t_flags done");
    endtask
    task t_modes;
        for (int i = 0; i < 6; i++) begin
            cfg(MODES[i]);
            chk("link_mode", 32'(link_mode), 32'(MODES[i][59:56]));
            chk("capture_en", 32'(capture_en), 32'h1);
            chk("lanes_active", 32'(lanes_active), 32'(MODES[i][7:0]));
            chk("descramble_en", 32'(descramble_en), 32'(MODES[i][55]));
            rchk(ADDR_OPF, MODES[i][47:40] + 8'h01);
            rchk(ADDR_CHECK_FLAGS, 8'h00);
        end
        $display("t_modes done");
    endtask
    task t_order;
        cfg(MODES[2]);
        spi(1'b0, ADDR_DESKEW_MASK, 8'h03);
        chk("capture_en", 32'(capture_en), 32'h0);
        spi(1'b0, ADDR_LANE_EN, 8'h01);
        chk("capture_en", 32'(capture_en), 32'h0);
        spi(1'b0, ADDR_LANE_EN, 8'h03);
        chk("lanes_active", 32'(lanes_active), 32'h3);
        $display("t_order done");
    endtask
    task t_data;
        int n;
        load = 4'h3;
        tick(1);
        load = 4'h0;
        tick(10);
        chk("lane_ready", 32'(lane_ready), 32'h0);
        chk("beats_left", {28'h0, left}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            n = 0;
            while (sample_valid !== 1'b1 && n < 20) begin
                tick(1);
                n++;
            end
            chk("sample_data", sample_data, {16'h0, 8'h11 + i[7:0], 8'h22 + i[7:0]});
            chk("sample_conv", 32'(sample_conv[0]), 32'(i[0]));
            chk("sample_two", 32'(sample_two), 32'h0);
            sample_ready = 1'b1;
            tick(1);
            sample_ready = 1'b0;
            tick(1);
        end
        $display("t_data done");
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 70000) begin
            err_count++;
            test_done;
        end
    end
    initial begin
        reset = 1'b1;
        spi_csb_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        sample_ready = 1'b0;
        load = 4'h0;
        tick(3);
        reset = 1'b0;
        tick(8);
        t_reset;
        t_flags;
        t_modes;
        t_order;
        t_data;
        test_done;
    end
endmodule
`default_nettype wire
